// ===== rtl/fcm_host.sv
// Host-side controller for a parallel NOR flash command interface.
// Software orders single bus cycles and command sequences over APB;
// the flash pins are driven with fixed, conservative strobe timing.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps

// Contract
// - Write only with chip enable and write strobe low, output high.
// - Host must write reset to leave autoselect mode.
// - On timing-limit flag the host writes reset to regain array read.
// - Autoselect entry is two unlock writes then autoselect command.
module fcm_host #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input wire logic clock,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash pins
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN,
    output logic [AW-1:0] flashAddr,
    input wire logic [DW-1:0] flashDqIn,
    output logic [DW-1:0] flashDqOut,
    output logic flashDqOe,
    // Supply monitor, high while below the supply_lockout_level
    input wire logic supplyLow
);
    fcm_pkg::fcm_state_t state, next_state;
    logic [2:0] op;
    logic [1:0] step;
    logic [AW-1:0] addrReg;
    logic [DW-1:0] wdataReg;
    logic [DW-1:0] rdataReg;
    logic autoMode;
    logic queryMode;
    logic timingLimit;
    logic refused;
    logic expired;
    logic loadTimer;
    logic [7:0] loadValue;

    // ==========================================================
    // APB decode; the slave always answers in the access cycle
    wire apbWr = psel && penable && pwrite;
    wire apbRd = psel && penable && !pwrite;
    wire hitCtrl = (paddr == fcm_pkg::REG_CTRL);
    wire hitAddr = (paddr == fcm_pkg::REG_ADDR);
    wire hitWdata = (paddr == fcm_pkg::REG_WDATA);
    wire hitRdata = (paddr == fcm_pkg::REG_RDATA);
    wire hitStatus = (paddr == fcm_pkg::REG_STATUS);
    wire hitAny = hitCtrl | hitAddr | hitWdata | hitRdata | hitStatus;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hitAny;

    // ==========================================================
    // Operation launch and refusal
    wire [2:0] reqOp = pwdata[fcm_pkg::CTRL_OP_LSB +: 3];
    wire busy = (state != fcm_pkg::S_IDLE);
    wire isWriteOp = (reqOp == fcm_pkg::OP_WRITE) ||
                     (reqOp == fcm_pkg::OP_RESET) ||
                     (reqOp == fcm_pkg::OP_AUTOSEL) ||
                     (reqOp == fcm_pkg::OP_QUERY);
    wire isReadOp = (reqOp == fcm_pkg::OP_READ) ||
                    (reqOp == fcm_pkg::OP_POLL);
    wire ctrlWr = apbWr && hitCtrl && !busy;
    // No write operation starts while the supply is low
    wire lockRefuse = isWriteOp && supplyLow;
    // After a timing-limit hit only reset or reads go out
    wire limitRefuse = timingLimit && isWriteOp &&
                       (reqOp != fcm_pkg::OP_RESET);
    wire startOp = ctrlWr && (isWriteOp || isReadOp) &&
                   !lockRefuse && !limitRefuse;
    wire refuseOp = ctrlWr && (lockRefuse || limitRefuse);

    // ==========================================================
    // Command table: unlock, unlock, command for autoselect; one cycle for query and reset
    wire curIsRead = (op == fcm_pkg::OP_READ) || (op == fcm_pkg::OP_POLL);
    wire [1:0] lastStep = (op == fcm_pkg::OP_AUTOSEL) ? 2'd2 : 2'd0;
    logic [15:0] seqAddr;
    logic [15:0] seqData;
    always_comb begin
        seqAddr = fcm_pkg::UNLOCK1_ADDR;
        seqData = fcm_pkg::UNLOCK1_DATA;
        if (op == fcm_pkg::OP_AUTOSEL && step == 2'd1) begin
            seqAddr = fcm_pkg::UNLOCK2_ADDR;
            seqData = fcm_pkg::UNLOCK2_DATA;
        end else if (op == fcm_pkg::OP_AUTOSEL && step == 2'd2) begin
            seqData = fcm_pkg::AUTOSEL_DATA;
        end else if (op == fcm_pkg::OP_QUERY) begin
            seqAddr = fcm_pkg::QUERY_ADDR;
            seqData = fcm_pkg::QUERY_DATA;
        end else if (op == fcm_pkg::OP_RESET) begin
            // Address is a don't-care for the reset command
            seqData = fcm_pkg::RESET_DATA;
        end
    end
    wire useSeq = (op != fcm_pkg::OP_WRITE) && !curIsRead;
    wire [AW-1:0] cycAddr = useSeq ? AW'(seqAddr) : addrReg;
    wire [DW-1:0] cycData = useSeq ? DW'(seqData) : wdataReg;

    // ==========================================================
    // Sequencer: setup, strobe, hold per bus cycle
    wire cycDone = (state == fcm_pkg::S_HOLD) && expired;
    wire opDone = cycDone && (step == lastStep);
    always_comb begin
        next_state = state;
        loadTimer = 1'b0;
        loadValue = fcm_pkg::SETUP_CYC;
        unique case (state)
            fcm_pkg::S_IDLE: begin
                if (startOp) begin
                    next_state = fcm_pkg::S_SETUP;
                    loadTimer = 1'b1;
                end
            end
            fcm_pkg::S_SETUP: begin
                if (expired) begin
                    next_state = fcm_pkg::S_STROBE;
                    loadTimer = 1'b1;
                    loadValue = curIsRead ? fcm_pkg::ACC_CYC
                                          : fcm_pkg::WP_CYC;
                end
            end
            fcm_pkg::S_STROBE: begin
                if (expired) begin
                    next_state = fcm_pkg::S_HOLD;
                    loadTimer = 1'b1;
                    loadValue = fcm_pkg::HOLD_CYC;
                end
            end
            fcm_pkg::S_HOLD: begin
                if (expired) begin
                    next_state = opDone ? fcm_pkg::S_IDLE
                                        : fcm_pkg::S_SETUP;
                    loadTimer = !opDone;
                end
            end
        endcase
    end

    fcm_phase_timer #(.WIDTH(8)) phaseTimer (
        .clock(clock),
        .resetn(resetn),
        .load(loadTimer),
        .loadValue(loadValue),
        .expired(expired)
    );

    // ==========================================================
    // Pin levels for the next cycle; chip enable frames the whole
    // cycle so write strobe falls later and rises first
    wire nxtActive = (next_state != fcm_pkg::S_IDLE);
    wire nxtStrobe = (next_state == fcm_pkg::S_STROBE);
    wire nextCeN = !nxtActive;
    // Write strobe only with chip enable low and output high
    wire nextWeN = !(nxtStrobe && !curIsRead);
    wire nextOeN = !(nxtStrobe && curIsRead);
    wire nextDqOe = nxtActive && !curIsRead;

    // Registered pins; reset leaves every strobe high
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flashCeN <= 1'b1;
            flashWeN <= 1'b1;
            flashOeN <= 1'b1;
            flashDqOe <= 1'b0;
        end else begin
            flashCeN <= nextCeN;
            flashWeN <= nextWeN;
            flashOeN <= nextOeN;
            flashDqOe <= nextDqOe;
        end
    end

    // Address and data follow the current step
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flashAddr <= '0;
            flashDqOut <= '0;
        end else if (nxtActive) begin
            flashAddr <= cycAddr;
            flashDqOut <= cycData;
        end
    end

    // ==========================================================
    // Sequencer state and step
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= fcm_pkg::S_IDLE;
            op <= 3'h0;
            step <= 2'd0;
        end else begin
            state <= next_state;
            if (startOp) begin
                op <= reqOp;
                step <= 2'd0;
            end else if (cycDone && !opDone) begin
                step <= step + 2'd1;
            end
        end
    end

    // ==========================================================
    // Software registers; read data is taken at the end of access
    wire strobeEnd = (state == fcm_pkg::S_STROBE) && expired;
    wire readTake = strobeEnd && curIsRead;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            addrReg <= '0;
            wdataReg <= '0;
            rdataReg <= '0;
        end else begin
            if (apbWr && hitAddr) begin
                addrReg <= pwdata[AW-1:0];
            end
            if (apbWr && hitWdata) begin
                wdataReg <= pwdata[DW-1:0];
            end
            if (readTake) begin
                rdataReg <= flashDqIn;
            end
        end
    end

    // ==========================================================
    // Mode tracking: only a finished reset leaves autoselect or
    // query mode, so software sees when identification reads end
    wire resetDone = opDone && (op == fcm_pkg::OP_RESET);
    wire limitHit = readTake && (op == fcm_pkg::OP_POLL) &&
                    flashDqIn[fcm_pkg::TLIMIT_BIT];
    wire refusedClr = apbWr && hitStatus && pwdata[fcm_pkg::ST_REFUSED];
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            autoMode <= 1'b0;
            queryMode <= 1'b0;
            timingLimit <= 1'b0;
            refused <= 1'b0;
        end else begin
            // Autoselect holds until reset is written
            if (opDone && op == fcm_pkg::OP_AUTOSEL) begin
                autoMode <= 1'b1;
            end else if (resetDone) begin
                autoMode <= 1'b0;
            end
            if (opDone && op == fcm_pkg::OP_QUERY) begin
                queryMode <= 1'b1;
            end else if (resetDone) begin
                queryMode <= 1'b0;
            end
            // Set wins over the clear by reset
            timingLimit <= limitHit | (timingLimit & !resetDone);
            refused <= refuseOp | (refused & !refusedClr);
        end
    end

    // ==========================================================
    // Read mux
    wire [31:0] statusWord = 32'({supplyLow, refused, timingLimit,
                                  queryMode, autoMode, busy});
    assign prdata = !apbRd ? 32'h0 :
                    hitCtrl ? 32'(op) :
                    hitAddr ? 32'(addrReg) :
                    hitWdata ? 32'(wdataReg) :
                    hitRdata ? 32'(rdataReg) :
                    hitStatus ? statusWord : 32'h0;

    // ==========================================================
    // Checks
    logic [7:0] weLowCnt;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            weLowCnt <= 8'h00;
        end else begin
            weLowCnt <= flashWeN ? 8'h00 : weLowCnt + 8'h01;
        end
    end

    sequence startAutosel;
        startOp && reqOp == fcm_pkg::OP_AUTOSEL;
    endsequence
    sequence autoselSettled;
        !busy && autoMode;
    endsequence

    chk_write_strobes: assert property (
        @(posedge clock) disable iff (!resetn)
        !flashWeN |-> (!flashCeN && flashOeN && flashDqOe))
        else $error("write strobe low without chip enable or with output");
    chk_oe_no_drive: assert property (
        @(posedge clock) disable iff (!resetn)
        !flashOeN |-> (!flashDqOe && flashWeN))
        else $error("output enable low while driving data");
    chk_we_width: assert property (
        @(posedge clock) disable iff (!resetn)
        $rose(flashWeN) |-> $past(weLowCnt) >= fcm_pkg::WP_CYC)
        else $error("write pulse shorter than minimum");
    chk_ce_frames_we: assert property (
        @(posedge clock) disable iff (!resetn)
        $rose(flashWeN) |-> !flashCeN)
        else $error("chip enable rose with write strobe");
    chk_lockout_refuse: assert property (
        @(posedge clock) disable iff (!resetn)
        (ctrlWr && isWriteOp && supplyLow) |=> (!busy && refused))
        else $error("write operation started under supply lockout");
    chk_autosel_entry: assert property (
        @(posedge clock) disable iff (!resetn)
        startAutosel |=> busy ##[60:200] autoselSettled)
        else $error("autoselect entry did not finish in time");
    chk_reset_exit: assert property (
        @(posedge clock) disable iff (!resetn)
        resetDone |=> (!autoMode && !queryMode))
        else $error("mode flag survived a reset command");
    chk_limit_gate: assert property (
        @(posedge clock) disable iff (!resetn)
        (timingLimit && ctrlWr && reqOp == fcm_pkg::OP_WRITE) |=> !busy)
        else $error("write issued while timing limit pending");
    chk_powerup_quiet: assert property (
        @(posedge clock) disable iff (!resetn)
        (!busy && !$past(busy)) |-> (flashWeN && flashCeN))
        else $error("strobe active while idle");
endmodule // fcm_host

// ===== rtl/fcm_pkg.sv
// Shared constants of the flash command host: register map, field
// positions, operation codes and strobe timing.
// Assumes a 250 MHz system clock and a 16-bit parallel flash part.
package fcm_pkg;

    // ==========================================================
    // Register map (byte addresses, one 32-bit word each)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // ==========================================================
    // Field positions
    localparam int CTRL_OP_LSB = 0;   // CTRL[2:0] operation code
    localparam int ST_BUSY = 0;
    localparam int ST_AUTOSEL = 1;
    localparam int ST_QUERY = 2;
    localparam int ST_TLIMIT = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_SUPPLY = 5;
    localparam int TLIMIT_BIT = 5;    // Timing-limit flag on data bit 5

    // ==========================================================
    // Operation codes written to CTRL
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h2;
    localparam logic [2:0] OP_RESET = 3'h3;
    localparam logic [2:0] OP_AUTOSEL = 3'h4;
    localparam logic [2:0] OP_QUERY = 3'h5;
    localparam logic [2:0] OP_POLL = 3'h6;

    // ==========================================================
    // Command words (word-mode addresses)
    localparam logic [15:0] UNLOCK1_ADDR = 16'h0555;
    localparam logic [15:0] UNLOCK2_ADDR = 16'h02aa;
    localparam logic [15:0] QUERY_ADDR = 16'h0055;
    localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] AUTOSEL_DATA = 16'h0090;
    localparam logic [15:0] QUERY_DATA = 16'h0098;
    localparam logic [15:0] RESET_DATA = 16'h00f0;

    // ==========================================================
    // Strobe timing, in ns, and derived clock counts (rounded up)
    localparam int CLK_NS = 4;
    localparam int T_SETUP_NS = 10;
    localparam int T_WP_NS = 35;
    localparam int T_HOLD_NS = 20;
    localparam int T_ACC_NS = 70;
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);

    // ==========================================================
    // Bus-cycle sequencer states
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_SETUP = 4'b0010,
        S_STROBE = 4'b0100,
        S_HOLD = 4'b1000
    } fcm_state_t;

endpackage

// ===== rtl/fcm_phase_timer.sv
// Phase timer for the flash bus-cycle sequencer.
// Assumes load is a one-cycle pulse from the sequencer's own clock.
`timescale 1ns/1ps
module fcm_phase_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic expired
);
    logic [WIDTH-1:0] count;

    // ==========================================================
    // Down counter; a load wins over the running count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (load) begin
            count <= loadValue;
        end else if (count != '0) begin
            count <= count - WIDTH'(1);
        end
    end

    assign expired = (count == '0);
endmodule // fcm_phase_timer

// ===== test/fcm_flash_model.sv
// Behavioural model of the parallel flash part: command decoding,
// identification reads and the extended query table.
// Assumes the host pins, supplyLow and limitEvent are its only stimulus; it has no clock.
`timescale 1ns/1ps
module fcm_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00c3,  // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h2a5e  // Arbitrary value
) (
    input wire logic ceN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic [19:0] addr,
    input wire logic [15:0] dqIn,
    input wire logic supplyLow,
    input wire logic limitEvent,
    output logic [15:0] dqOut
);
    // ==========================================================
    // Command state; mode 0 array, 1 autoselect, 2 query
    logic [1:0] mode = 2'h0;  // Array read from power-up
    logic [1:0] step = 2'h0;
    logic armed = 1'b0;  // Needs a falling strobe first
    logic limitHit = 1'b0;
    logic [19:0] latA = '0;
    logic [15:0] lastOut = '0;
    logic [15:0] readVal;

    task automatic goRead();
        mode = 2'h0;
        step = 2'h0;
    endtask

    // Address taken when the later strobe falls
    always @(negedge weN or negedge ceN) begin
        if (!weN && !ceN && oeN) begin
            latA = addr;
            armed = 1'b1;
        end
    end

    // Data taken when the earlier strobe rises
    always @(posedge weN or posedge ceN) begin
        if (armed && !supplyLow) begin
            if (dqIn == 16'h00f0) begin
                goRead();
                limitHit = 1'b0;
            end else if (step == 2'h0 && latA[15:0] == 16'h0555
                         && dqIn == 16'h00aa) begin
                step = 2'h1;
            end else if (step == 2'h1 && latA[15:0] == 16'h02aa
                         && dqIn == 16'h0055) begin
                step = 2'h2;
            end else if (step == 2'h2 && latA[15:0] == 16'h0555
                         && dqIn == 16'h0090) begin
                mode = 2'h1;
                step = 2'h0;
            end else if (step == 2'h0 && latA[15:0] == 16'h0055
                         && dqIn == 16'h0098) begin
                mode = 2'h2;
            end else begin
                goRead();
            end
        end
        armed = 1'b0;
    end

    // Lockout resets the state machine
    always @(posedge supplyLow) goRead();
    always @(posedge limitEvent) limitHit = 1'b1;

    // Read value selected by mode, address and the limit flag
    always @* begin
        case (mode)
            2'h1: begin
                case (addr[7:0])
                    8'h00: readVal = MAKER_CODE;
                    8'h01: readVal = DEVICE_CODE;
                    8'h02: readVal = {15'h0, addr[19:16] == 4'h1};
                    default: readVal = addr[15:0] ^ 16'h5a5a;
                endcase
            end
            2'h2: begin
                case (addr[7:0])
                    8'h40: readVal = 16'h0050;
                    8'h41: readVal = 16'h0052;
                    8'h42: readVal = 16'h0049;
                    8'h43: readVal = 16'h0031;
                    8'h44: readVal = 16'h0030;
                    8'h46: readVal = 16'h0002;
                    8'h47: readVal = 16'h0001;
                    8'h48: readVal = 16'h0001;
                    8'h49: readVal = 16'h0004;
                    8'h4c: readVal = 16'h0002;
                    default: readVal = 16'h0000;
                endcase
            end
            default: readVal = limitHit ? 16'h0020 : addr[15:0] ^ 16'h5a5a;
        endcase
    end

    // A released bus shows the inverse of the last word, never a copy
    always @(posedge oeN) lastOut = readVal;
    assign dqOut = (!ceN && !oeN) ? readVal : ~lastOut;
endmodule  // fcm_flash_model

// ===== test/fcm_host_tb.sv
// Self-checking bench of the flash command host with a flash model.
// Assumes the APB slave answers on its own and one 250 MHz clock.
`timescale 1ns/1ps
module fcm_host_tb;
    localparam logic [15:0] MAKER = 16'h00c3;  // Arbitrary value
    localparam logic [15:0] DEVICE = 16'h2a5e;  // Arbitrary value
    localparam logic [15:0] QTAB [13] = '{16'h50, 16'h52, 16'h49,
        16'h31, 16'h30, 16'h0, 16'h2, 16'h1, 16'h1, 16'h4, 16'h0, 16'h0,
        16'h2};
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, flashCeN, flashWeN, flashOeN, flashDqOe, err;
    logic [19:0] flashAddr;
    logic [15:0] flashDqOut, modelDq, dqBus;
    logic supplyLow = 1'b0;
    logic limitEvent = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int wePulses = 0;

    always #2 clock = ~clock;
    // Wire level from whichever side drives the data lines
    assign dqBus = flashDqOe ? flashDqOut : modelDq;
    // Strobes that must qualify every write pulse
    wire [2:0] weQual = {flashCeN, flashOeN, flashDqOe};

    fcm_host u_fcm_host (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
        .flashAddr(flashAddr), .flashDqIn(dqBus), .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe), .supplyLow(supplyLow));
    fcm_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
        u_fcm_flash_model (.ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN),
        .addr(flashAddr), .dqIn(dqBus), .supplyLow(supplyLow),
        .limitEvent(limitEvent), .dqOut(modelDq));

    // ==========================================================
    // Checking and closing
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 1500 cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    // Every write pulse must be qualified by the other strobes
    always @(negedge flashWeN) begin
        wePulses++;
        check("write qualifiers", 32'(weQual), 32'h3);
    end

    // ==========================================================
    // Bus tasks; an idle edge follows so psel never toggles twice
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic runOp(input logic [2:0] op);
        apb(1'b1, fcm_pkg::REG_CTRL, 32'(op));
        rd = 32'h1;
        while (rd[fcm_pkg::ST_BUSY] !== 1'b0) begin
            apb(1'b0, fcm_pkg::REG_STATUS, 32'h0);
        end
    endtask

    task automatic flashRead(input logic [19:0] a);
        apb(1'b1, fcm_pkg::REG_ADDR, 32'(a));
        runOp(fcm_pkg::OP_READ);
        apb(1'b0, fcm_pkg::REG_RDATA, 32'h0);
    endtask

    task automatic flashWrite(input logic [19:0] a, input logic [15:0] d);
        apb(1'b1, fcm_pkg::REG_ADDR, 32'(a));
        apb(1'b1, fcm_pkg::REG_WDATA, 32'(d));
        runOp(fcm_pkg::OP_WRITE);
    endtask

    function automatic logic [31:0] arrayWord(input logic [19:0] a);
        return {16'h0, a[15:0] ^ 16'h5a5a};
    endfunction

    // ==========================================================
    // Scenarios
    task automatic testIdle();
        check("idle", 32'({flashCeN, flashWeN, flashOeN, flashDqOe}), 32'he);
        apb(1'b0, fcm_pkg::REG_STATUS, 32'h0);
        check("status after reset", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        flashRead(20'h00123);
        check("array at power-up", rd, arrayWord(20'h00123));
    endtask

    task automatic testQuery();
        runOp(fcm_pkg::OP_QUERY);
        check("query flag", 32'(rd[fcm_pkg::ST_QUERY]), 32'h1);
        for (int i = 0; i < 13; i++) begin
            flashRead(20'(32'h40 + i));
            check("qry", rd, 32'(QTAB[i]));
        end
        runOp(fcm_pkg::OP_RESET);
        flashRead(20'h00041);
        check("array after reset", rd, arrayWord(20'h00041));
    endtask

    task automatic testAutosel();
        int n;
        n = wePulses;
        apb(1'b1, fcm_pkg::REG_CTRL, 32'(fcm_pkg::OP_AUTOSEL));
        // A CTRL write while busy is dropped, so this reset never goes out
        runOp(fcm_pkg::OP_RESET);
        check("unlock pulses", 32'(wePulses - n), 32'h3);
        check("auto flag", 32'(rd[fcm_pkg::ST_AUTOSEL]), 32'h1);
        flashRead(20'h00300);
        check("maker code", rd, 32'(MAKER));
        flashRead(20'h00401);
        check("device code", rd, 32'(DEVICE));
        flashRead(20'h10002);
        check("protected sector", rd, 32'h1);
        flashRead(20'h20002);
        check("open sector", rd, 32'h0);
        flashRead(20'h00000);
        check("maker code again", rd, 32'(MAKER));
        runOp(fcm_pkg::OP_RESET);
        flashRead(20'h00000);
        check("array after exit", rd, arrayWord(20'h00000));
    endtask

    // Reset after the two unlock cycles must drop the partial sequence
    task automatic testAbort();
        flashWrite(20'h00555, 16'h00aa);
        flashWrite(20'h002aa, 16'h0055);
        runOp(fcm_pkg::OP_RESET);
        flashWrite(20'h00555, 16'h0090);
        flashRead(20'h00000);
        check("aborted", rd, arrayWord(20'h00000));
    endtask

    task automatic testBadWrite();
        runOp(fcm_pkg::OP_QUERY);
        apb(1'b1, fcm_pkg::REG_ADDR, 32'h00100);
        apb(1'b1, fcm_pkg::REG_WDATA, 32'h1234);
        runOp(fcm_pkg::OP_WRITE);
        flashRead(20'h00042);
        check("array after bad write", rd, arrayWord(20'h00042));
    endtask

    task automatic testLimit();
        limitEvent <= 1'b1;
        apb(1'b1, fcm_pkg::REG_ADDR, 32'h00010);
        runOp(fcm_pkg::OP_POLL);
        check("limit set", 32'(rd[fcm_pkg::ST_TLIMIT]), 32'h1);
        runOp(fcm_pkg::OP_WRITE);
        check("refused", 32'(rd[fcm_pkg::ST_REFUSED]), 32'h1);
        runOp(fcm_pkg::OP_RESET);
        check("limit clear", 32'(rd[fcm_pkg::ST_TLIMIT]), 32'h0);
        apb(1'b1, fcm_pkg::REG_STATUS, 32'h10);
        apb(1'b0, fcm_pkg::REG_STATUS, 32'h0);
        check("refused cleared", 32'(rd[fcm_pkg::ST_REFUSED]), 32'h0);
        flashRead(20'h00010);
        check("array after limit", rd, arrayWord(20'h00010));
        limitEvent <= 1'b0;
    endtask

    task automatic testSupply();
        int n;
        runOp(fcm_pkg::OP_AUTOSEL);
        supplyLow <= 1'b1;
        n = wePulses;
        runOp(fcm_pkg::OP_WRITE);
        check("supply flag", 32'(rd[fcm_pkg::ST_SUPPLY]), 32'h1);
        check("lockout", 32'(rd[fcm_pkg::ST_REFUSED]), 32'h1);
        check("no write pulses", 32'(wePulses - n), 32'h0);
        apb(1'b1, fcm_pkg::REG_STATUS, 32'h10);
        supplyLow <= 1'b0;
        flashRead(20'h00000);
        check("array after lockout", rd, arrayWord(20'h00000));
    endtask

    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        testIdle();
        testQuery();
        testAutosel();
        testAbort();
        testBadWrite();
        testLimit();
        testSupply();
        print_verdict();
    end
endmodule  // fcm_host_tb
